// ### hw/ibc_pkg.sv
`default_nettype none
package ibc_pkg;

    // system clock and master serial clock timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_HALF_NS   = 5000;
    localparam int SCL_HALF_CYC_I = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W         = 10;
    localparam logic [DIV_W-1:0] SCL_HALF_CYC = DIV_W'(SCL_HALF_CYC_I);

    // bit counter positions within a byte
    localparam logic [3:0] CNT_PRE  = 4'hF;
    localparam logic [3:0] CNT_LAST = 4'h7;
    localparam logic [3:0] CNT_ACK  = 4'h8;

    // extension code prefixes in the upper nibble of the first byte
    localparam logic [3:0] EXT_PFX_A = 4'h0;
    localparam logic [3:0] EXT_PFX_B = 4'hF;

    // values after reset
    localparam logic [7:0] SHIFT_RST = 8'h00;
    localparam logic       SPD_RST   = 1'b1;
    localparam logic       PIN_RST   = 1'b1;

    // master sequencer states
    typedef enum logic [1:0] {
        MS_IDLE  = 2'b00,
        MS_START = 2'b01,
        MS_RUN   = 2'b10,
        MS_STOP  = 2'b11
    } ibc_mst_e;

    // phases of start and stop generation
    localparam logic [1:0] PH_SETUP = 2'h0;
    localparam logic [1:0] PH_HIGH  = 2'h1;
    localparam logic [1:0] PH_EDGE  = 2'h2;

endpackage : ibc_pkg
`default_nettype wire

// ### hw/ibc_sync.sv
`default_nettype none
module ibc_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // asynchronous level in, synchronised level out
    input  wire logic d_async,
    output logic      q_sync
);

    logic meta_r;

    // two-flop synchroniser; the first stage feeds only the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= RST_VAL;
            q_sync <= RST_VAL;
        end else begin
            meta_r <= d_async;
            q_sync <= meta_r;
        end
    end

endmodule : ibc_sync
`default_nettype wire

// ### hw/ibc_bus_protocol_control.sv
// Operation
// - start is data falling while clock high
// - start when triggered after stop; flag starts
// - slave compares seven address bits, stays selected
// - address byte sent and received via shift
// - direction bit zero writes, one reads
// - ninth clock low is ack; transmitter records
// - receiver acks data only with ack enable
// - role flag updated at eighth address bit
// - own address always acked, other non-extension addresses never
// - extension code acked if enable preset
// - irq timing follows wait timing select
// - stop is data rising while clock high
// - stop trigger; stop flag; irq if enabled
// - master clocks; honours slave clock stretch
// - wait after start and per timing select
// - wait released by write, release, triggers while master
// - unit disable aborts and releases wait
// - exit bit leaves communication, releases wait
// - both lines open drain, pull low only
// - receiving master nacks last byte then stops
// - shift write in wait starts new byte
// - own address bit zero ignored
// - irq and wait on serial clock falling edge; stop irq on the stop condition
`default_nettype none
module ibc_bus_protocol_control (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // open-drain serial clock pin
    input  wire logic       serial_clock_pin_i,
    output logic            serial_clock_pin_o,
    output logic            serial_clock_pin_oe,
    // open-drain serial data pin
    input  wire logic       serial_data_pin_i,
    output logic            serial_data_pin_o,
    output logic            serial_data_pin_oe,
    // control levels
    input  wire logic       unit_enable,
    input  wire logic       ack_enable,
    input  wire logic       wait_timing_select,
    input  wire logic       stop_irq_enable,
    // control pulses
    input  wire logic       start_trigger,
    input  wire logic       stop_trigger,
    input  wire logic       wait_release,
    input  wire logic       comm_exit,
    // shift data and own address
    input  wire logic       shift_data_wr,
    input  wire logic [7:0] shift_data_wdata,
    input  wire logic [7:0] own_address_reg,
    output logic      [7:0] shift_data_reg,
    // status
    output logic            start_detected_flag,
    output logic            stop_detected_flag,
    output logic            ack_detected_flag,
    output logic            transmit_role_flag,
    output logic            master_active,
    output logic            wait_state,
    output logic            addr_match_flag,
    output logic            ext_code_flag,
    output logic            bus_event_irq
);

    logic                     scl_s;
    logic                     sda_s;
    logic                     scl_d_r;
    logic                     sda_d_r;
    logic                     scl_rise;
    logic                     scl_fall;
    logic                     start_det;
    logic                     stop_det;
    logic                     abort;
    logic                     master_w;
    logic                     involved;
    logic [7:0]               byte_in;
    logic                     addr_hit;
    logic                     ext_hit;
    logic                     bit_slot;
    logic                     ack_slot;
    logic                     tx_now;
    logic                     rx_ack;
    logic                     sw_release;
    logic                     div_done;
    logic                     seq_drive;
    ibc_pkg::ibc_mst_e        ms_r;
    ibc_pkg::ibc_mst_e        ms_nxt;
    logic [1:0]               ph_r;
    logic [1:0]               ph_nxt;
    logic [ibc_pkg::DIV_W-1:0] div_r;
    logic [ibc_pkg::DIV_W-1:0] div_nxt;
    logic                     mscl_r;
    logic                     mscl_nxt;
    logic                     msda_r;
    logic                     msda_nxt;
    logic                     set_wait_m;
    logic [3:0]               cnt_r;
    logic [3:0]               cnt_nxt;
    logic [7:0]               shift_r;
    logic [7:0]               shift_nxt;
    logic                     samp_r;
    logic                     samp_nxt;
    logic                     busy_r;
    logic                     busy_nxt;
    logic                     addr_ph_r;
    logic                     addr_ph_nxt;
    logic                     trc_r;
    logic                     trc_nxt;
    logic                     sel_r;
    logic                     sel_nxt;
    logic                     ext_r;
    logic                     ext_nxt;
    logic                     ack_addr_r;
    logic                     ack_addr_nxt;
    logic                     ackd_r;
    logic                     ackd_nxt;
    logic                     wait_r;
    logic                     wait_nxt;
    logic                     std_r;
    logic                     std_nxt;
    logic                     spd_r;
    logic                     spd_nxt;
    logic                     irq_r;
    logic                     irq_nxt;
    logic                     scl_oe_r;
    logic                     sda_oe_r;

    // pin inputs into the clock domain
    ibc_sync #(.RST_VAL(ibc_pkg::PIN_RST)) u_scl_sync (
        .clk     (clk),
        .resetn  (resetn),
        .d_async (serial_clock_pin_i),
        .q_sync  (scl_s)
    );
    ibc_sync #(.RST_VAL(ibc_pkg::PIN_RST)) u_sda_sync (
        .clk     (clk),
        .resetn  (resetn),
        .d_async (serial_data_pin_i),
        .q_sync  (sda_s)
    );

    // previous synced levels for edge finding
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_d_r <= ibc_pkg::PIN_RST;
            sda_d_r <= ibc_pkg::PIN_RST;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // bus condition and edge decode
    assign scl_rise  = scl_s & ~scl_d_r;
    assign scl_fall  = ~scl_s & scl_d_r;
    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
    assign abort     = ~unit_enable | comm_exit;

    // byte and address decode
    assign master_w = (ms_r != ibc_pkg::MS_IDLE);
    assign involved = master_w | sel_r | ext_r;
    assign byte_in  = {shift_r[6:0], samp_r};
    assign addr_hit = (byte_in[7:1] == own_address_reg[7:1]);
    assign ext_hit  = (byte_in[7:4] == ibc_pkg::EXT_PFX_A) |
                      (byte_in[7:4] == ibc_pkg::EXT_PFX_B);
    assign bit_slot = ~cnt_r[3];
    assign ack_slot = (cnt_r == ibc_pkg::CNT_ACK);

    // who drives data and who acknowledges
    assign tx_now = (addr_ph_r & master_w) | (~addr_ph_r & trc_r & involved);
    assign rx_ack = addr_ph_r ? ack_addr_r
                              : (~trc_r & involved & ack_enable);

    // software actions that end a wait
    assign sw_release = wait_r & (shift_data_wr | wait_release |
                        (master_w & (start_trigger | stop_trigger)));

    assign div_done  = (div_r == ibc_pkg::SCL_HALF_CYC - 10'd1);
    // data stays low after start until the clock fall is seen
    assign seq_drive = (ms_r == ibc_pkg::MS_START) | (ms_r == ibc_pkg::MS_STOP) |
                       ((ms_r == ibc_pkg::MS_RUN) & (cnt_r == ibc_pkg::CNT_PRE));

    // master sequencer: start, clocking, stop
    always_comb begin
        ms_nxt     = ms_r;
        ph_nxt     = ph_r;
        div_nxt    = div_r + 10'd1;
        mscl_nxt   = mscl_r;
        msda_nxt   = msda_r;
        set_wait_m = 1'b0;
        case (ms_r)
            ibc_pkg::MS_IDLE: begin
                mscl_nxt = 1'b0;
                msda_nxt = 1'b0;
                if (start_trigger & spd_r & unit_enable) begin
                    ms_nxt  = ibc_pkg::MS_START;
                    ph_nxt  = ibc_pkg::PH_SETUP;
                    div_nxt = '0;
                end
            end
            ibc_pkg::MS_START: begin
                case (ph_r)
                    ibc_pkg::PH_SETUP: begin
                        msda_nxt = 1'b0;
                        if (div_done) begin
                            ph_nxt   = ibc_pkg::PH_HIGH;
                            mscl_nxt = 1'b0;
                            div_nxt  = '0;
                        end
                    end
                    ibc_pkg::PH_HIGH: begin
                        if (!scl_s) begin
                            div_nxt = '0;
                        end else if (div_done) begin
                            ph_nxt   = ibc_pkg::PH_EDGE;
                            msda_nxt = 1'b1;
                            div_nxt  = '0;
                        end
                    end
                    default: begin
                        if (div_done) begin
                            mscl_nxt   = 1'b1;
                            ms_nxt     = ibc_pkg::MS_RUN;
                            set_wait_m = 1'b1;
                            div_nxt    = '0;
                        end
                    end
                endcase
            end
            ibc_pkg::MS_RUN: begin
                if (wait_r & stop_trigger) begin
                    ms_nxt  = ibc_pkg::MS_STOP;
                    ph_nxt  = ibc_pkg::PH_SETUP;
                    div_nxt = '0;
                end else if (wait_r & start_trigger) begin
                    ms_nxt  = ibc_pkg::MS_START;
                    ph_nxt  = ibc_pkg::PH_SETUP;
                    div_nxt = '0;
                end else if (wait_r) begin
                    mscl_nxt = 1'b1;
                    div_nxt  = '0;
                end else if (mscl_r) begin
                    if (div_done) begin
                        mscl_nxt = 1'b0;
                        div_nxt  = '0;
                    end
                end else if (!scl_s) begin
                    div_nxt = '0;
                end else if (div_done) begin
                    mscl_nxt = 1'b1;
                    div_nxt  = '0;
                end
            end
            ibc_pkg::MS_STOP: begin
                case (ph_r)
                    ibc_pkg::PH_SETUP: begin
                        mscl_nxt = 1'b1;
                        msda_nxt = 1'b1;
                        if (div_done) begin
                            ph_nxt   = ibc_pkg::PH_HIGH;
                            mscl_nxt = 1'b0;
                            div_nxt  = '0;
                        end
                    end
                    ibc_pkg::PH_HIGH: begin
                        if (!scl_s) begin
                            div_nxt = '0;
                        end else if (div_done) begin
                            ph_nxt   = ibc_pkg::PH_EDGE;
                            msda_nxt = 1'b0;
                            div_nxt  = '0;
                        end
                    end
                    default: begin
                        if (div_done) begin
                            ms_nxt = ibc_pkg::MS_IDLE;
                        end
                    end
                endcase
            end
            default: begin
                ms_nxt = ibc_pkg::MS_IDLE;
            end
        endcase
        if (abort) begin
            ms_nxt     = ibc_pkg::MS_IDLE;
            mscl_nxt   = 1'b0;
            msda_nxt   = 1'b0;
            set_wait_m = 1'b0;
        end
    end

    // byte engine: conditions, shifting, ack, waits
    always_comb begin
        cnt_nxt      = cnt_r;
        shift_nxt    = shift_r;
        samp_nxt     = samp_r;
        busy_nxt     = busy_r;
        addr_ph_nxt  = addr_ph_r;
        trc_nxt      = trc_r;
        sel_nxt      = sel_r;
        ext_nxt      = ext_r;
        ack_addr_nxt = ack_addr_r;
        ackd_nxt     = ackd_r;
        wait_nxt     = wait_r;
        std_nxt      = std_r;
        spd_nxt      = spd_r;
        irq_nxt      = 1'b0;
        if (sw_release) begin
            wait_nxt = 1'b0;
        end
        if (shift_data_wr) begin
            shift_nxt = shift_data_wdata;
        end
        if (start_det) begin
            busy_nxt    = 1'b1;
            cnt_nxt     = ibc_pkg::CNT_PRE;
            addr_ph_nxt = 1'b1;
            trc_nxt     = 1'b0;
            sel_nxt     = 1'b0;
            ext_nxt     = 1'b0;
            ackd_nxt    = 1'b0;
            std_nxt     = 1'b1;
            spd_nxt     = 1'b0;
        end else if (stop_det) begin
            busy_nxt    = 1'b0;
            cnt_nxt     = ibc_pkg::CNT_PRE;
            addr_ph_nxt = 1'b0;
            trc_nxt     = 1'b0;
            sel_nxt     = 1'b0;
            ext_nxt     = 1'b0;
            ackd_nxt    = 1'b0;
            wait_nxt    = 1'b0;
            std_nxt     = 1'b0;
            spd_nxt     = 1'b1;
            irq_nxt     = stop_irq_enable;
        end else if (busy_r & scl_rise) begin
            if (bit_slot) begin
                samp_nxt = sda_s;
            end else if (ack_slot & tx_now) begin
                ackd_nxt = ~sda_s;
            end
        end else if (busy_r & scl_fall) begin
            case (cnt_r)
                ibc_pkg::CNT_PRE: begin
                    cnt_nxt = 4'h0;
                end
                ibc_pkg::CNT_LAST: begin
                    shift_nxt = byte_in;
                    cnt_nxt   = ibc_pkg::CNT_ACK;
                    if (addr_ph_r & master_w) begin
                        trc_nxt      = ~samp_r;
                        ack_addr_nxt = 1'b0;
                    end else if (addr_ph_r) begin
                        sel_nxt      = addr_hit;
                        ext_nxt      = ext_hit & ~addr_hit;
                        trc_nxt      = addr_hit & samp_r;
                        ack_addr_nxt = addr_hit | (ext_hit & ack_enable);
                        if (ext_hit & ~addr_hit) begin
                            wait_nxt = 1'b1;
                            irq_nxt  = 1'b1;
                        end
                    end else if (involved & ~wait_timing_select) begin
                        wait_nxt = 1'b1;
                        irq_nxt  = 1'b1;
                    end
                end
                ibc_pkg::CNT_ACK: begin
                    cnt_nxt     = 4'h0;
                    addr_ph_nxt = 1'b0;
                    if (involved & (wait_timing_select | (addr_ph_r & ~ext_r))) begin
                        wait_nxt = 1'b1;
                        irq_nxt  = 1'b1;
                    end
                end
                default: begin
                    if (bit_slot) begin
                        shift_nxt = byte_in;
                        cnt_nxt   = cnt_r + 4'h1;
                    end
                end
            endcase
        end
        if (set_wait_m) begin
            wait_nxt = 1'b1;
            irq_nxt  = 1'b1;
        end
        if (abort) begin
            wait_nxt    = 1'b0;
            busy_nxt    = 1'b0;
            sel_nxt     = 1'b0;
            ext_nxt     = 1'b0;
            trc_nxt     = 1'b0;
            addr_ph_nxt = 1'b0;
            cnt_nxt     = ibc_pkg::CNT_PRE;
        end
        if (!unit_enable) begin
            std_nxt  = 1'b0;
            ackd_nxt = 1'b0;
        end
    end

    // master sequencer registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ms_r   <= ibc_pkg::MS_IDLE;
            ph_r   <= ibc_pkg::PH_SETUP;
            div_r  <= '0;
            mscl_r <= 1'b0;
            msda_r <= 1'b0;
        end else begin
            ms_r   <= ms_nxt;
            ph_r   <= ph_nxt;
            div_r  <= div_nxt;
            mscl_r <= mscl_nxt;
            msda_r <= msda_nxt;
        end
    end

    // byte engine datapath registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r      <= ibc_pkg::CNT_PRE;
            shift_r    <= ibc_pkg::SHIFT_RST;
            samp_r     <= 1'b0;
            busy_r     <= 1'b0;
            addr_ph_r  <= 1'b0;
            ack_addr_r <= 1'b0;
        end else begin
            cnt_r      <= cnt_nxt;
            shift_r    <= shift_nxt;
            samp_r     <= samp_nxt;
            busy_r     <= busy_nxt;
            addr_ph_r  <= addr_ph_nxt;
            ack_addr_r <= ack_addr_nxt;
        end
    end

    // byte engine status registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trc_r  <= 1'b0;
            sel_r  <= 1'b0;
            ext_r  <= 1'b0;
            ackd_r <= 1'b0;
            wait_r <= 1'b0;
            std_r  <= 1'b0;
            spd_r  <= ibc_pkg::SPD_RST;
            irq_r  <= 1'b0;
        end else begin
            trc_r  <= trc_nxt;
            sel_r  <= sel_nxt;
            ext_r  <= ext_nxt;
            ackd_r <= ackd_nxt;
            wait_r <= wait_nxt;
            std_r  <= std_nxt;
            spd_r  <= spd_nxt;
            irq_r  <= irq_nxt;
        end
    end

    // pin pull-down enables, registered
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else begin
            scl_oe_r <= unit_enable & (mscl_r | wait_r);
            sda_oe_r <= unit_enable & (seq_drive ? msda_r :
                        ((bit_slot & tx_now & ~shift_r[7]) | (ack_slot & rx_ack)));
        end
    end

    // open-drain pins: low or released only
    assign serial_clock_pin_o  = 1'b0;
    assign serial_data_pin_o   = 1'b0;
    assign serial_clock_pin_oe = scl_oe_r;
    assign serial_data_pin_oe  = sda_oe_r;

    // status outputs from registers
    assign shift_data_reg      = shift_r;
    assign start_detected_flag = std_r;
    assign stop_detected_flag  = spd_r;
    assign ack_detected_flag   = ackd_r;
    assign transmit_role_flag  = trc_r;
    assign master_active       = master_w;
    assign wait_state          = wait_r;
    assign addr_match_flag     = sel_r;
    assign ext_code_flag       = ext_r;
    assign bus_event_irq       = irq_r;

endmodule : ibc_bus_protocol_control
`default_nettype wire

// ### bench/ibc_bpc_props.sv
`default_nettype none
module ibc_bpc_props (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pins
    input wire logic serial_clock_pin_i,
    input wire logic serial_clock_pin_oe,
    input wire logic serial_data_pin_oe,
    // controls
    input wire logic unit_enable,
    input wire logic stop_irq_enable,
    input wire logic wait_release,
    input wire logic comm_exit,
    input wire logic shift_data_wr,
    // status
    input wire logic start_detected_flag,
    input wire logic stop_detected_flag,
    input wire logic master_active,
    input wire logic wait_state,
    input wire logic bus_event_irq
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);

    rel_bit_a: assert property (wait_state && wait_release |=> !wait_state)
        else $error("release ignored");
    rel_wr_a: assert property (wait_state && shift_data_wr |=> !wait_state)
        else $error("write kept wait");
    exit_rel_a: assert property (comm_exit |-> ##[1:3] !wait_state && !serial_clock_pin_oe)
        else $error("exit kept wait");
    off_rel_a: assert property ((!unit_enable) [*3] |-> !serial_data_pin_oe && !wait_state)
        else $error("disabled but active");
    wait_scl_a: assert property ($rose(wait_state) |-> ##[0:2] serial_clock_pin_oe)
        else $error("wait without clock low");
    stop_irq_a: assert property ($rose(stop_detected_flag) && stop_irq_enable |-> ##[0:1] bus_event_irq)
        else $error("stop without irq");
    start_flag_a: assert property ($rose(start_detected_flag) |-> ##[0:1] !stop_detected_flag)
        else $error("stop flag kept on start");
    start_gen_a: assert property ($rose(serial_data_pin_oe) && $past(serial_clock_pin_i, 2)
        && serial_clock_pin_i |-> master_active)
        else $error("data fell in clock high as slave");
endmodule : ibc_bpc_props

bind ibc_bus_protocol_control ibc_bpc_props u_props (.*);
`default_nettype wire

// ### bench/ibc_bus_peer.sv
`default_nettype none
module ibc_bus_peer (
    // line levels
    input wire logic scl,
    input wire logic sda,
    // pull-low enables
    output logic scl_oe,
    output logic sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    // data falls while clock high
    task automatic start;
        sda_oe = 1'b1;
        #62;
        scl_oe = 1'b1;
    endtask : start
    // one clock pulse, waits out a stretch
    task automatic pulse(input logic b, output logic s);
        #20;
        sda_oe = ~b;
        #42;
        scl_oe = 1'b0;
        wait (scl);
        #30;
        s = sda;
        #32;
        scl_oe = 1'b1;
    endtask : pulse
    // msb first, ninth pulse samples ack
    task automatic send_byte(input logic [7:0] d, output logic a);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(d[i], s);
        end
        pulse(1'b1, s);
        a = ~s;
    endtask : send_byte
    // data rises while clock high
    task automatic stop;
        #20;
        sda_oe = 1'b1;
        #42;
        scl_oe = 1'b0;
        wait (scl);
        #62;
        sda_oe = 1'b0;
    endtask : stop
    // addressed slave: ack in ninth bit
    task automatic ack_slave;
        repeat (9) @(negedge scl);
        #20;
        sda_oe = 1'b1;
        @(negedge scl);
        #20;
        sda_oe = 1'b0;
    endtask : ack_slave
endmodule : ibc_bus_peer
`default_nettype wire

// ### bench/ibc_bus_protocol_control_test.sv
`default_nettype none
module ibc_bus_protocol_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, resetn = 1'b0, en = 1'b1, acke = 1'b1, wts = 1'b1;
    logic [4:0] ctl = 5'h00;
    logic [7:0] wd = 8'h00;
    wire logic sclo, sdao, pscl, psda, ws, spd, std, ackd, trc, mact, amf, ecf;
    wire logic [7:0] sh;
    wire logic scl = !(sclo | pscl);
    wire logic sda = !(sdao | psda);
    int n_checks = 0, n_mismatch = 0;
    always #5 clk = ~clk;
    ibc_bus_protocol_control u_dut (.clk(clk), .resetn(resetn),
        .serial_clock_pin_i(scl), .serial_clock_pin_o(), .serial_clock_pin_oe(sclo),
        .serial_data_pin_i(sda), .serial_data_pin_o(), .serial_data_pin_oe(sdao),
        .unit_enable(en), .ack_enable(acke), .wait_timing_select(wts),
        .stop_irq_enable(1'b1), .start_trigger(ctl[1]), .stop_trigger(ctl[2]),
        .wait_release(ctl[0]), .comm_exit(ctl[3]), .shift_data_wr(ctl[4]),
        .shift_data_wdata(wd), .own_address_reg(8'hA4), .shift_data_reg(sh),
        .start_detected_flag(std), .stop_detected_flag(spd), .ack_detected_flag(ackd),
        .transmit_role_flag(trc), .master_active(mact), .wait_state(ws),
        .addr_match_flag(amf), .ext_code_flag(ecf), .bus_event_irq());
    ibc_bus_peer u_peer (.scl(scl), .sda(sda), .scl_oe(pscl), .sda_oe(psda));
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (!ok) begin
            n_mismatch++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk
    // one-cycle control pulse, k selects the bit
    task automatic strobe(input int k);
        @(posedge clk);
        ctl <= 5'(1 << k);
        @(posedge clk);
        ctl <= 5'h00;
    endtask : strobe
    task automatic wait_ws(input logic v);
        int n;
        n = 0;
        while (ws !== v && n < 20000) begin
            @(negedge clk);
            n++;
        end
        chk(n < 20000, "wait state timeout");
    endtask : wait_ws
    task automatic t_slave;
        logic a;
        u_peer.start();
        u_peer.send_byte(8'hA4, a);
        chk(a === 1'b1 && amf === 1'b1 && sh === 8'hA4, "own address");
        wait_ws(1'b1);
        chk(trc === 1'b0 && std === 1'b1, "role after address");
        strobe(0);
        u_peer.send_byte(8'h3C, a);
        chk(a === 1'b1 && sh === 8'h3C, "data ack");
        wait_ws(1'b1);
        @(posedge clk);
        acke <= 1'b0;
        wts <= 1'b0;
        strobe(0);
        fork
            u_peer.send_byte(8'hC3, a);
            begin
                wait_ws(1'b0);
                wait_ws(1'b1);
                chk(sh === 8'hC3, "eight clock wait");
                strobe(0);
            end
        join
        repeat (6) @(negedge clk);
        chk(a === 1'b0 && ws === 1'b0, "ack while disabled");
        @(posedge clk);
        acke <= 1'b1;
        wts <= 1'b1;
        u_peer.stop();
        repeat (10) @(negedge clk);
        chk(spd === 1'b1 && std === 1'b0 && amf === 1'b0, "stop seen");
    endtask : t_slave
    task automatic t_other;
        logic a;
        u_peer.start();
        u_peer.send_byte(8'h66, a);
        repeat (20) @(negedge clk);
        chk(a === 1'b0 && amf === 1'b0 && ecf === 1'b0 && ws === 1'b0, "foreign address");
        u_peer.stop();
        repeat (10) @(negedge clk);
    endtask : t_other
    task automatic t_master;
        fork
            u_peer.ack_slave();
            begin
                strobe(1);
                wait_ws(1'b1);
                chk(std === 1'b1 && spd === 1'b0 && mact === 1'b1, "start");
                @(posedge clk);
                wd <= 8'h5A;
                strobe(4);
                wait_ws(1'b0);
                wait_ws(1'b1);
            end
        join
        chk(ackd === 1'b1 && trc === 1'b1 && sh === 8'h5A, "address sent");
        strobe(2);
        repeat (2000) @(negedge clk);
        chk(spd === 1'b1 && mact === 1'b0, "stop made");
    endtask : t_master
    task automatic t_abort;
        strobe(1);
        wait_ws(1'b1);
        strobe(3);
        repeat (3) @(negedge clk);
        chk(ws === 1'b0 && sclo === 1'b0 && sdao === 1'b0, "exit");
        @(posedge clk);
        en <= 1'b0;
        repeat (4) @(negedge clk);
        chk(ws === 1'b0 && std === 1'b0, "disable");
    endtask : t_abort
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(negedge clk);
        chk(spd === 1'b1 && sh === 8'h00 && sclo === 1'b0 && sdao === 1'b0, "reset");
        t_slave();
        t_other();
        t_master();
        t_abort();
        give_verdict();
    end
    // watchdog
    initial begin
        #400us;
        n_mismatch++;
        give_verdict();
    end
endmodule : ibc_bus_protocol_control_test
`default_nettype wire
